/* File: rtl/bmam_defines.svh */
// Address map constants for the banked memory address map block.
// Assumes inclusion by its bare name from the package, the top module and the checker.
`ifndef BMAM_DEFINES_SVH
`define BMAM_DEFINES_SVH
// Program space
`define BMAM_PC_W          13
`define BMAM_INSN_W        14
`define BMAM_PMEM_AW       12
`define BMAM_RESET_VEC     13'h0000
`define BMAM_IRQ_VEC       13'h0004
// Data space
`define BMAM_DADDR_W       9
`define BMAM_LOC_W         7
`define BMAM_BANK_TOP      7'h7f
// Core and peripheral register offsets within a bank
`define BMAM_OFS_INDIRECT  7'h00
`define BMAM_OFS_PC_LO     7'h02
`define BMAM_OFS_STATUS    7'h03
`define BMAM_OFS_FPTR      7'h04
`define BMAM_OFS_PORT_D    7'h08
`define BMAM_OFS_PORT_E    7'h09
`define BMAM_OFS_PC_LATCH  7'h0a
`define BMAM_OFS_INTCTL    7'h0b
`define BMAM_OFS_CONV_RES  7'h1e
`define BMAM_OFS_CONV_CTL  7'h1f
`define BMAM_OFS_GPR_LO    7'h20
// Status field positions
`define BMAM_BANK_HI_BIT   6
`define BMAM_BANK_LO_BIT   5
// Reset values
`define BMAM_RST_BYTE      8'h00
`define BMAM_RST_STATUS    8'h18
// Latch keeps only the five bits that reach the counter
`define BMAM_LATCH_MASK    8'h1f
`endif

/* File: rtl/bmam_pkg.sv */
// Types shared by the banked memory address map block.
// Assumes bmam_defines.svh is on the include path.
`include "bmam_defines.svh"
package bmam_pkg;
   // Data access request from the core
   typedef struct packed {
      logic                       rd;
      logic                       wr;
      logic                       indirect;
      logic [`BMAM_LOC_W-1:0]     loc;
      logic [7:0]                 wdata;
   } bmam_dreq_t;
   // Program fetch controls from the core
   typedef struct packed {
      logic                       advance;
      logic                       irq_take;
      logic                       jump;
      logic [`BMAM_PC_W-1:0]      target;
   } bmam_fetch_t;
   // Region decode of a data address
   typedef enum logic [2:0] {
      BMAM_R_GAP    = 3'b000,
      BMAM_R_PC_LO  = 3'b001,
      BMAM_R_STATUS = 3'b010,
      BMAM_R_FPTR   = 3'b011,
      BMAM_R_PC_LATCH = 3'b100,
      BMAM_R_INTCTL = 3'b101,
      BMAM_R_SFR    = 3'b110,
      BMAM_R_GPR    = 3'b111
   } bmam_region_t;
endpackage

/* File: rtl/bmam_top.sv */
// Banked data memory and program counter addressing for a small core.
// Assumes one clock, the core as sole master, synchronous request inputs.
// Summary of operation
// - Program counter is 13 bits, addressing 8K words of 14 bits.
// - Only 4K words exist; higher fetch addresses wrap onto them.
// - Any reset loads the program counter with 0000h.
// - A taken interrupt sends execution to 0004h.
// - Status bits 6:5 pick the bank; 00 bank 0, 01 bank 1.
// - Each bank spans 128 locations, offsets 00h to 7Fh.
// - Low bank part holds special registers; RAM at 20h-7Fh and A0h-FFh.
// - Access direct or via file pointer; 00h/80h read the pointed location.
// - Counter low, status, pointer, latch and interrupt control mirror in both banks.
// - Converter registers read zero on variants without the converter.
// - Fetch and data access use separate buses, same cycle.
// - Peripheral special registers are static RAM cells inside the banks; core registers are flops.
`timescale 1ns/10ps
`include "bmam_defines.svh"
module bmam_top
   import bmam_pkg::*;
#(
   parameter bit HAS_PORTS_DE  = 1'b1,
   parameter bit HAS_CONVERTER = 1'b1
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Instruction fetch side
   input  wire bmam_fetch_t              fetch,
   output logic [`BMAM_PC_W-1:0]         pc_out,
   output logic [`BMAM_INSN_W-1:0]       insn_out,
   // Program memory load port
   input  wire logic                     pload_we,
   input  wire logic [`BMAM_PMEM_AW-1:0] pload_addr,
   input  wire logic [`BMAM_INSN_W-1:0]  pload_data,
   // Data access side
   input  wire bmam_dreq_t               dreq,
   output logic [7:0]                    drdata,
   output logic                          drvalid,
   // Core register view
   output logic [7:0]                    status_out,
   output logic [7:0]                    intctl_out
);

   // Storage: SFR cells and general RAM as static arrays
   logic [`BMAM_INSN_W-1:0] pmem [0:(1<<`BMAM_PMEM_AW)-1];
   logic [7:0]              dmem [0:(1<<`BMAM_DADDR_W)-1];
   logic [`BMAM_PC_W-1:0]   pc_ff;
   logic [`BMAM_PC_W-1:0]   nxt_pc;
   logic [7:0]              status_ff;
   logic [7:0]              fptr_ff;
   logic [7:0]              pc_latch_ff;
   logic [7:0]              intctl_ff;
   logic [`BMAM_INSN_W-1:0] insn_ff;
   logic [7:0]              drdata_ff;
   logic                    drvalid_ff;

   // Region decode, used for both direct and indirect addresses
   function automatic bmam_region_t region_of(input logic [8:0] a);
      logic [6:0] o;
      bmam_region_t r;
      o = a[6:0];
      r = BMAM_R_GAP;
      if (a[8]) begin
         r = BMAM_R_GAP;
      end else if (o >= `BMAM_OFS_GPR_LO) begin
         r = BMAM_R_GPR;
      end else begin
         unique case (o)
            `BMAM_OFS_PC_LO:    r = BMAM_R_PC_LO;
            `BMAM_OFS_STATUS: r = BMAM_R_STATUS;
            `BMAM_OFS_FPTR:   r = BMAM_R_FPTR;
            `BMAM_OFS_PC_LATCH: r = BMAM_R_PC_LATCH;
            `BMAM_OFS_INTCTL: r = BMAM_R_INTCTL;
            `BMAM_OFS_INDIRECT: r = BMAM_R_GAP;
            `BMAM_OFS_PORT_D, `BMAM_OFS_PORT_E:
               r = HAS_PORTS_DE ? BMAM_R_SFR : BMAM_R_GAP;
            `BMAM_OFS_CONV_RES:
               r = (HAS_CONVERTER && !a[7]) ? BMAM_R_SFR : BMAM_R_GAP;
            `BMAM_OFS_CONV_CTL:
               r = HAS_CONVERTER ? BMAM_R_SFR : BMAM_R_GAP;
            default: r = BMAM_R_SFR;
         endcase
      end
      return r;
   endfunction

   // Effective data address
   wire [1:0]          bank_sel  = {status_ff[`BMAM_BANK_HI_BIT],
                                    status_ff[`BMAM_BANK_LO_BIT]};
   wire [8:0]          dir_addr  = {bank_sel, dreq.loc};
   wire                via_ptr   = dreq.indirect || (dreq.loc == `BMAM_OFS_INDIRECT);
   // Pointer reaches 00h-FFh; a pointer aimed at 00h/80h itself reads zero
   wire [8:0]          ind_addr  = {1'b0, fptr_ff};
   wire [8:0]          eff_addr  = via_ptr ? ind_addr : dir_addr;
   wire bmam_region_t  eff_reg   = region_of(eff_addr);
   wire [8:0]          cell_addr = {2'b00, eff_addr[6:0]} |
                                   {1'b0, eff_addr[7], 7'h00};
   wire                wr_hit    = dreq.wr && (eff_reg != BMAM_R_GAP);

   // Write strobes, one per core register and one for the static cells
   wire wr_pc_lo  = wr_hit && (eff_reg == BMAM_R_PC_LO);
   wire wr_status = wr_hit && (eff_reg == BMAM_R_STATUS);
   wire wr_fptr   = wr_hit && (eff_reg == BMAM_R_FPTR);
   wire wr_latch  = wr_hit && (eff_reg == BMAM_R_PC_LATCH);
   wire wr_intctl = wr_hit && (eff_reg == BMAM_R_INTCTL);
   wire wr_cell   = wr_hit && (eff_reg == BMAM_R_SFR || eff_reg == BMAM_R_GPR);

   // Data map as decoded above, offsets within a bank:
   //   00h        indirect window, no cell behind it
   //   02h        counter low byte, one flop for both banks
   //   03h        status, one flop for both banks
   //   04h        file pointer, one flop for both banks
   //   08h, 09h   fourth and fifth port cells, gap when absent
   //   0Ah        counter upper latch, one flop for both banks
   //   0Bh        interrupt control, one flop for both banks
   //   1Eh        converter result, bank 0 only, gap when absent
   //   1Fh        converter control cells, gap when absent
   //   other low  peripheral cells, plain static storage here
   //   20h-7Fh    general RAM, separate cells per bank
   // Bank codes 10 and 11 fall on the upper address bit and read zero.
   // Peripheral cells hold data only; their side effects live elsewhere.
   // The indirect path carries no bank bits of its own beyond the
   // pointer's top bit, so it reaches banks 0 and 1 only.
   // A pointer aimed back at the window itself reads zero, which
   // avoids an endless chain of lookups through the same location.
   // Trade-off: cell storage is a 512 entry array for simple indexing,
   // half of it never addressed; synthesis trims the unused words.
   // Hazard: a read and a write to one cell in one cycle return the
   // old value, since the answer is taken before the write lands.

   // Read data selection
   logic [7:0] rd_mux;
   always_comb begin
      unique case (eff_reg)
         BMAM_R_PC_LO:  rd_mux = pc_ff[7:0];
         BMAM_R_STATUS: rd_mux = status_ff;
         BMAM_R_FPTR:   rd_mux = fptr_ff;
         BMAM_R_PC_LATCH: rd_mux = pc_latch_ff;
         BMAM_R_INTCTL: rd_mux = intctl_ff;
         BMAM_R_GAP:    rd_mux = `BMAM_RST_BYTE;
         default:       rd_mux = dmem[cell_addr];
      endcase
   end

   // Program counter next value; a write to counter low jumps using the latch
   wire [`BMAM_PC_W-1:0] pc_inc = `BMAM_PC_W'(pc_ff + 13'h0001);
   always_comb begin
      if (fetch.irq_take) begin
         nxt_pc = `BMAM_IRQ_VEC;
      end else if (wr_pc_lo) begin
         nxt_pc = {pc_latch_ff[4:0], dreq.wdata};
      end else if (fetch.jump) begin
         nxt_pc = fetch.target;
      end else if (fetch.advance) begin
         nxt_pc = pc_inc;
      end else begin
         nxt_pc = pc_ff;
      end
   end

   // Program counter; any reset restarts at the reset vector
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_ff <= `BMAM_RESET_VEC;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // Status holds the bank pair, so every direct access depends on it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= `BMAM_RST_STATUS;
      end else if (wr_status) begin
         status_ff <= dreq.wdata;
      end
   end

   // File pointer, shared by both banks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fptr_ff <= `BMAM_RST_BYTE;
      end else if (wr_fptr) begin
         fptr_ff <= dreq.wdata;
      end
   end

   // Upper latch; unused top bits dropped so reads show zero there
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_latch_ff <= `BMAM_RST_BYTE;
      end else if (wr_latch) begin
         pc_latch_ff <= dreq.wdata & `BMAM_LATCH_MASK;
      end
   end

   // Interrupt control, shared by both banks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intctl_ff <= `BMAM_RST_BYTE;
      end else if (wr_intctl) begin
         intctl_ff <= dreq.wdata;
      end
   end

   // Static data cells carry no reset, as in a real RAM
   always_ff @(posedge clk) begin
      if (wr_cell) begin
         dmem[cell_addr] <= dreq.wdata;
      end
   end

   // Program store load port; the core never writes it
   always_ff @(posedge clk) begin
      if (pload_we) begin
         pmem[pload_addr] <= pload_data;
      end
   end

   // Fetch bus, independent of the data bus; upper counter bit ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         insn_ff <= '0;
      end else begin
         insn_ff <= pmem[pc_ff[`BMAM_PMEM_AW-1:0]];
      end
   end

   // Read data, registered one cycle after the request; zero when idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drdata_ff <= `BMAM_RST_BYTE;
      end else begin
         drdata_ff <= dreq.rd ? rd_mux : `BMAM_RST_BYTE;
      end
   end

   // Read answer flag, one pulse per read request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drvalid_ff <= 1'b0;
      end else begin
         drvalid_ff <= dreq.rd;
      end
   end

   assign pc_out     = pc_ff;
   assign insn_out   = insn_ff;
   assign drdata     = drdata_ff;
   assign drvalid    = drvalid_ff;
   assign status_out = status_ff;
   assign intctl_out = intctl_ff;

endmodule

/* File: test/banked_memory_address_map_bench.sv */
// Bench for the address map, small variant without ports D/E or converter.
// Assumes bmam_core_model drives the data side.
`timescale 1ns/10ps
module banked_memory_address_map_bench
   import bmam_pkg::*;
;
   logic        clk, rst_n, pload_we, drvalid, ok;
   logic [11:0] pload_addr;
   logic [13:0] pload_data, insn_out;
   logic [12:0] pc_out;
   logic [7:0]  drdata, status_out, intctl_out, rd_v;
   bmam_fetch_t fetch;
   bmam_dreq_t  dreq;
   int          bad_count = 0;
   int          n_tests = 0;
   localparam logic [6:0] GAPS [4] = '{7'h08, 7'h09, 7'h1e, 7'h1f};
   bmam_top #(.HAS_PORTS_DE(1'b0), .HAS_CONVERTER(1'b0)) DUT (.clk(clk), .rst_n(rst_n),
      .fetch(fetch), .pc_out(pc_out), .insn_out(insn_out), .pload_we(pload_we),
      .pload_addr(pload_addr), .pload_data(pload_data), .dreq(dreq), .drdata(drdata),
      .drvalid(drvalid), .status_out(status_out), .intctl_out(intctl_out));
   bmam_core_model cpu (.clk(clk), .dreq(dreq), .drdata(drdata), .drvalid(drvalid));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] loc, input logic [7:0] d);
      cpu.access(1'b0, 1'b1, 1'b0, loc, d, rd_v, ok);
   endtask
   // Answer must be valid and carry the expected byte
   task automatic rd(input logic [6:0] loc, input logic ind, input logic [7:0] exp);
      cpu.access(1'b1, 1'b0, ind, loc, 8'h00, rd_v, ok);
      check({7'h00, ok, rd_v}, {8'h01, exp}, "read");
   endtask
   task automatic prog_wrap();
      @(posedge clk);
      pload_we <= 1'b1;
      pload_addr <= 12'h005;
      pload_data <= 14'h2abc;
      @(posedge clk);
      pload_we <= 1'b0;
      fetch <= '{1'b0, 1'b0, 1'b1, 13'h1005};
      @(posedge clk);
      fetch <= '0;
      @(posedge clk);
      #1;
      check(pc_out, 13'h1005, "jump");
      check(insn_out, 14'h2abc, "wrapped fetch");
      @(posedge clk);
      fetch <= '{1'b1, 1'b1, 1'b0, 13'h0000};
      @(posedge clk);
      fetch <= '{1'b1, 1'b0, 1'b0, 13'h0000};
      #1;
      check(pc_out, 13'h0004, "irq vector");
      @(posedge clk);
      fetch <= '0;
      #1;
      check(pc_out, 13'h0005, "advance");
   endtask
   task automatic data_map();
      wr(7'h20, 8'h5a);
      wr(7'h7f, 8'h3c);
      wr(7'h03, 8'h20);
      check(status_out, 8'h20, "status write");
      // Bank 1 copies of the absent registers read zero too
      foreach (GAPS[i]) begin
         wr(GAPS[i], 8'hff);
         rd(GAPS[i], 1'b0, 8'h00);
      end
      wr(7'h20, 8'ha5);
      wr(7'h04, 8'ha0);
      wr(7'h0b, 8'h81);
      check(intctl_out, 8'h81, "intctl write");
      rd(7'h20, 1'b0, 8'ha5);
      rd(7'h00, 1'b0, 8'ha5);
      rd(7'h1e, 1'b0, 8'h00);
      wr(7'h03, 8'h00);
      rd(7'h20, 1'b0, 8'h5a);
      rd(7'h7f, 1'b0, 8'h3c);
      rd(7'h0b, 1'b0, 8'h81);
      rd(7'h55, 1'b1, 8'ha5);
      foreach (GAPS[i]) begin
         wr(GAPS[i], 8'hff);
         rd(GAPS[i], 1'b0, 8'h00);
      end
      // Upper bank bit set on purpose: nothing is mapped there
      wr(7'h03, 8'h40);
      rd(7'h20, 1'b0, 8'h00);
   endtask
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      close_out();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      pload_we = 1'b0;
      pload_addr = 12'h000;
      pload_data = 14'h0000;
      fetch = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check(pc_out, 13'h0000, "pc reset");
      check(status_out, 8'h18, "status reset");
      check(intctl_out, 8'h00, "intctl reset");
      prog_wrap();
      data_map();
      close_out();
   end
endmodule

/* File: test/bmam_asserts.sv */
// Checker for the address map, watching the top ports only.
// Assumes one clock domain and bind by the foot of this file.
`timescale 1ns/10ps
`include "bmam_defines.svh"
module bmam_checker
   import bmam_pkg::*;
#(
   parameter bit HAS_PORTS_DE  = 1'b1,
   parameter bit HAS_CONVERTER = 1'b1
) (
   // Clock, reset and requests
   input wire logic              clk,
   input wire logic              rst_n,
   input wire bmam_fetch_t       fetch,
   input wire bmam_dreq_t        dreq,
   // Observed outputs
   input wire logic [12:0]       pc_out,
   input wire logic [7:0]        drdata,
   input wire logic              drvalid,
   input wire logic [7:0]        status_out,
   input wire logic [7:0]        intctl_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Direct write while a real bank is selected
   wire dwr = dreq.wr && !dreq.indirect && !status_out[6];
   wire drd = dreq.rd && !dreq.indirect;
   reset_vec_a: assert property ($rose(rst_n) |-> pc_out == 13'h0000)
      else $error("pc not at start after reset");
   irq_vec_a: assert property (fetch.irq_take |=> pc_out == 13'h0004)
      else $error("interrupt vector wrong");
   jump_load_a: assert property (fetch.jump && !fetch.irq_take
      |=> pc_out == $past(fetch.target)) else $error("jump target lost");
   pc_step_a: assert property (fetch.advance && !fetch.jump && !fetch.irq_take
      && !dreq.wr |=> pc_out == $past(pc_out) + 13'h0001) else $error("pc step");
   read_ans_a: assert property (dreq.rd |=> drvalid) else $error("no read answer");
   idle_zero_a: assert property (!dreq.rd |=> !drvalid && drdata == 8'h00)
      else $error("data out without read");
   bank_sel_a: assert property (dwr && dreq.loc == 7'h03
      |=> status_out[6:5] == $past(dreq.wdata[6:5])) else $error("bank bits");
   mirror_int_a: assert property (dwr && dreq.loc == 7'h0b
      |=> intctl_out == $past(dreq.wdata)) else $error("intctl write lost");
   conv_zero_a: assert property (drd && !HAS_CONVERTER && dreq.loc == 7'h1f
      |=> drdata == 8'h00) else $error("converter reads nonzero");
   port_zero_a: assert property (drd && !HAS_PORTS_DE && dreq.loc == 7'h08
      |=> drdata == 8'h00) else $error("port reads nonzero");
endmodule
bind bmam_top bmam_checker #(.HAS_PORTS_DE(HAS_PORTS_DE), .HAS_CONVERTER(HAS_CONVERTER))
   chk (.clk(clk), .rst_n(rst_n), .fetch(fetch), .dreq(dreq), .pc_out(pc_out),
   .drdata(drdata), .drvalid(drvalid), .status_out(status_out), .intctl_out(intctl_out));

/* File: test/bmam_core_model.sv */
// Core data side model: one access at a time.
// Assumes the bench calls access from one process only.
`timescale 1ns/10ps
module bmam_core_model
   import bmam_pkg::*;
(
   // Clock
   input  wire logic       clk,
   // Data access bus
   output bmam_dreq_t      dreq,
   input  wire logic [7:0] drdata,
   input  wire logic       drvalid
);
   initial dreq = '0;
   // Request held one edge; answer taken 1 ns after that same edge
   task automatic access(input logic rd, wr, ind, input logic [6:0] loc,
      input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
      @(posedge clk);
      dreq <= '{rd, wr, ind, loc, wd};
      @(posedge clk);
      dreq <= '0;
      #1;
      rdat = drdata;
      ok = !rd || drvalid === 1'b1;
   endtask
endmodule
